// [core/ixs_core.sv]
/*
 ixs_core: executes decrement-skip-nonzero, absolute jump, increment-file and
 increment-skip-zero in four quarters per instruction cycle, one quarter a clock.
 assumes program memory and data file answer combinationally in the same cycle.
*/
//
// Behaviour
// - decrement-skip-nonzero subtracts one; nonzero result turns next instruction into nop
// - decrement-skip-nonzero is one word, one cycle, two skipping, three over two-word
// - every skipped cycle is idle in all quarters; two-word skip idles twice
// - absolute jump loads its 20-bit literal into program counter bits 20..1
// - jump literal covers 0 to 1048575
// - jump is first word EF plus k7..0, second word F plus k19..8
// - jump takes two cycles, two words, no flag change
// - jump reads low byte in Q2, high bits and counter write in Q4, then idles
// - increment-file adds one and sets carry, digit carry, negative, overflow, zero
// - increment destination bit zero writes accumulator, one writes file register
// - bank-access bit zero addresses the access bank
// - access bit zero, extended set on, address up to 95 uses indexed offset
// - increment-skip-zero adds one, stores at destination, skips on zero result
// - increment-skip-zero changes no status flag
// - file operand spans 0..255 with one-bit destination and access selectors
// - bank-access bit one takes the bank from the bank select register
// - decrement destination zero writes accumulator, one writes file register
`timescale 1ns/1ps
module ixs_core
	import ixs_pkg::*;
#(
	parameter logic [3:0] ACCESS_HI_PAGE = 4'hF
)(
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// apb slave
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	// program memory
	output logic      [PC_W-1:0]  pm_addr,
	input  wire logic [15:0]      pm_data,
	// data file
	output ixs_file_req_type      file_req,
	input  wire logic [7:0]       file_rdata
);

	// ****************
	// state
	// ****************
	ixs_state_type s_r;
	ixs_state_type s_nxt;
	ixs_op_type    exec_op;
	logic          is_byte;
	logic          dst_file;
	logic          apb_setup;
	logic          apb_wr;

	// skipped cycles execute as nop whatever the word holds
	assign exec_op   = (s_r.skip != 2'h0) ? OP_NOP : ixs_decode(s_r.ir);
	assign is_byte   = (exec_op == OP_DEC_SNZ) || (exec_op == OP_INC) || (exec_op == OP_INC_SZ);
	assign dst_file  = s_r.ir[9];
	assign apb_setup = psel && !penable;
	assign apb_wr    = psel && penable && pwrite;

	// ****************
	// outputs
	// ****************
	assign pready         = psel && penable;
	assign prdata         = s_r.prdata;
	assign pslverr        = s_r.pslverr;
	assign pm_addr        = s_r.pc;
	assign file_req.rd    = s_r.run && (s_r.q == Q2) && is_byte;
	assign file_req.wr    = s_r.run && (s_r.q == Q4) && is_byte && dst_file;
	assign file_req.addr  = s_r.faddr;
	assign file_req.wdata = s_r.res;

	// ****************
	// next state
	// ****************
	always_comb
	begin
		s_nxt = s_r;
		// read data is latched in setup so the access phase shows a flop
		if (apb_setup)
		begin
			s_nxt.prdata  = 32'h0000_0000;
			s_nxt.pslverr = 1'b0;
			case (paddr)
				ADDR_CTRL:   s_nxt.prdata = {30'h0000_0000, s_r.ext, s_r.run};
				ADDR_BANK:   s_nxt.prdata = {28'h000_0000, s_r.bank_select_register};
				ADDR_WREG:   s_nxt.prdata = {24'h00_0000, s_r.wreg};
				ADDR_STATUS: s_nxt.prdata = {27'h000_0000, s_r.status};
				ADDR_PC:     s_nxt.prdata = {11'h000, s_r.pc};
				ADDR_INDEX:  s_nxt.prdata = {20'h0_0000, s_r.idx};
				default:     s_nxt.pslverr = 1'b1;
			endcase
		end
		if (apb_wr)
		begin
			case (paddr)
				ADDR_CTRL:
				begin
					s_nxt.run = pwdata[CTRL_RUN];
					s_nxt.ext = pwdata[CTRL_EXT];
				end
				ADDR_BANK:   s_nxt.bank_select_register = pwdata[3:0];
				ADDR_WREG:   s_nxt.wreg = pwdata[7:0];
				ADDR_STATUS: s_nxt.status = pwdata[4:0];
				ADDR_PC:
				begin
					// software writes reach the counter only while halted, odd bit stays clear
					if (!s_r.run)
						s_nxt.pc = {pwdata[PC_W-1:1], 1'b0};
				end
				ADDR_INDEX:  s_nxt.idx = pwdata[FA_W-1:0];
				default:     s_nxt.pslverr = s_r.pslverr;
			endcase
		end
		if (s_r.run)
		begin
			s_nxt.q = ixs_quarter_type'(s_r.q + 2'h1);
			case (s_r.q)
				Q1:
				begin
					if (is_byte)
					begin
						if (s_r.ir[8])
							s_nxt.faddr = {s_r.bank_select_register, s_r.ir[7:0]};
						else if (s_r.ext && (s_r.ir[7:0] <= ACC_LOW_MAX))
							s_nxt.faddr = s_r.idx + {4'h0, s_r.ir[7:0]};
						else if (s_r.ir[7:0] <= ACC_LOW_MAX)
							s_nxt.faddr = {4'h0, s_r.ir[7:0]};
						else
							s_nxt.faddr = {ACCESS_HI_PAGE, s_r.ir[7:0]};
					end
				end
				Q2:
				begin
					if (is_byte)
						s_nxt.opnd = file_rdata;
					if (exec_op == OP_JUMP)
						s_nxt.kl = s_r.ir[7:0];
				end
				Q3:
				begin
					if (exec_op == OP_DEC_SNZ)
						s_nxt.res = s_r.opnd - 8'h01;
					else if (is_byte)
						s_nxt.res = s_r.opnd + 8'h01;
				end
				Q4:
				begin
					// fetch of the following word overlaps every cycle
					s_nxt.ir = pm_data;
					s_nxt.pc = s_r.pc + PC_STEP;
					if (s_r.skip != 2'h0)
						s_nxt.skip = s_r.skip - 2'h1;
					if (is_byte && !dst_file)
						s_nxt.wreg = s_r.res;
					case (exec_op)
						OP_JUMP:
						begin
							// 20-bit literal spans the whole word range
							s_nxt.pc   = {pm_data[11:0], s_r.kl, 1'b0};
							s_nxt.skip = 2'h1;
						end
						OP_DEC_SNZ:
						begin
							if (s_r.res != 8'h00)
								s_nxt.skip = ixs_two_word(pm_data) ? 2'h2 : 2'h1;
						end
						OP_INC_SZ:
						begin
							if (s_r.res == 8'h00)
								s_nxt.skip = ixs_two_word(pm_data) ? 2'h2 : 2'h1;
						end
						OP_INC:
						begin
							s_nxt.status[ST_C]  = (s_r.opnd == BYTE_ONES);
							s_nxt.status[ST_DC] = (s_r.opnd[3:0] == NIB_ONES);
							s_nxt.status[ST_Z]  = (s_r.res == 8'h00);
							s_nxt.status[ST_OV] = (s_r.opnd == BYTE_MAXPOS);
							s_nxt.status[ST_N]  = s_r.res[7];
						end
						default: s_nxt.skip = s_nxt.skip;
					endcase
				end
				default: s_nxt.q = Q1;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s_r <= STATE_RST;
		else
			s_r <= s_nxt;
	end

	// ****************
	// checks
	// ****************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_q4(ixs_op_type op);
		s_r.run && (s_r.q == Q4) && (exec_op == op);
	endsequence

	sequence s_no_sw_status;
		!(apb_wr && (paddr == ADDR_STATUS));
	endsequence

	property p_quarter_walk;
		s_r.run && (s_r.q == Q1) && !apb_wr |=> (s_r.q == Q2) ##1 (s_r.q == Q3) ##1 (s_r.q == Q4);
	endproperty
	a_quarter_walk: assert property (p_quarter_walk) else $error("quarters out of order");

	property p_read_q2;
		file_req.rd |-> (s_r.q == Q2) && (s_r.skip == 2'h0);
	endproperty
	a_read_q2: assert property (p_read_q2) else $error("file read outside Q2");

	property p_dec_skip;
		s_q4(OP_DEC_SNZ) and (s_r.res != 8'h00) |=> (s_r.skip != 2'h0);
	endproperty
	a_dec_skip: assert property (p_dec_skip) else $error("nonzero decrement did not skip");

	property p_skip_two;
		s_q4(OP_DEC_SNZ) and (s_r.res != 8'h00) and ixs_two_word(pm_data) |=> (s_r.skip == 2'h2);
	endproperty
	a_skip_two: assert property (p_skip_two) else $error("two-word skip not two cycles");

	property p_skip_idle;
		(s_r.skip != 2'h0) |-> !file_req.rd && !file_req.wr;
	endproperty
	a_skip_idle: assert property (p_skip_idle) else $error("skipped cycle touched the file");

	property p_jump_pc;
		s_q4(OP_JUMP) |=> (s_r.pc == {$past(pm_data[11:0]), $past(s_r.kl), 1'b0}) && (s_r.skip == 2'h1);
	endproperty
	a_jump_pc: assert property (p_jump_pc) else $error("jump target wrong");

	property p_jump_flags;
		s_q4(OP_JUMP) and s_no_sw_status |=> $stable(s_r.status);
	endproperty
	a_jump_flags: assert property (p_jump_flags) else $error("jump changed flags");

	property p_inc_flags;
		s_q4(OP_INC) |=> (s_r.status[ST_Z] == ($past(s_r.res) == 8'h00))
			&& (s_r.status[ST_C] == ($past(s_r.opnd) == BYTE_ONES));
	endproperty
	a_inc_flags: assert property (p_inc_flags) else $error("increment flags wrong");

	property p_incsz_flags;
		s_q4(OP_INC_SZ) and s_no_sw_status |=> $stable(s_r.status);
	endproperty
	a_incsz_flags: assert property (p_incsz_flags) else $error("skip-zero changed flags");

	property p_dest_w;
		s_r.run && (s_r.q == Q4) && is_byte && !dst_file |=> (s_r.wreg == $past(s_r.res));
	endproperty
	a_dest_w: assert property (p_dest_w) else $error("accumulator not written");

	property p_bank_sel;
		s_r.run && (s_r.q == Q1) && is_byte && s_r.ir[8] |=> (s_r.faddr[11:8] == $past(s_r.bank_select_register));
	endproperty
	a_bank_sel: assert property (p_bank_sel) else $error("bank not from bank select");

	sequence s_q1_acc;
		s_r.run && (s_r.q == Q1) && is_byte && !s_r.ir[8];
	endsequence

	sequence s_no_sw_wreg;
		!(apb_wr && (paddr == ADDR_WREG));
	endsequence

	// a skipped or jumped-over cycle must leave the file alone in every quarter
	sequence s_idle_quarters;
		((exec_op == OP_NOP) && !file_req.rd && !file_req.wr) [*4];
	endsequence

	property p_access_low;
		s_q1_acc and (!s_r.ext && (s_r.ir[7:0] <= ACC_LOW_MAX)) |=> (s_r.faddr == {4'h0, s_r.ir[7:0]});
	endproperty
	a_access_low: assert property (p_access_low) else $error("access bank low half missed");

	property p_access_high;
		s_q1_acc and (s_r.ir[7:0] > ACC_LOW_MAX) |=> (s_r.faddr == {ACCESS_HI_PAGE, s_r.ir[7:0]});
	endproperty
	a_access_high: assert property (p_access_high) else $error("access bank high half missed");

	property p_indexed;
		s_q1_acc and (s_r.ext && (s_r.ir[7:0] <= ACC_LOW_MAX))
			|=> (s_r.faddr == $past(s_r.idx) + {4'h0, s_r.ir[7:0]});
	endproperty
	a_indexed: assert property (p_indexed) else $error("indexed offset address wrong");

	property p_jump_low;
		s_r.run && (s_r.q == Q2) && (exec_op == OP_JUMP) |=> (s_r.kl == $past(s_r.ir[7:0]));
	endproperty
	a_jump_low: assert property (p_jump_low) else $error("jump low literal not taken in Q2");

	property p_jump_idle;
		s_q4(OP_JUMP) |=> s_idle_quarters;
	endproperty
	a_jump_idle: assert property (p_jump_idle) else $error("cycle after jump not idle");

	property p_skip_count;
		s_r.run && (s_r.q == Q4) && (s_r.skip != 2'h0) |=> (s_r.skip == $past(s_r.skip) - 2'h1);
	endproperty
	a_skip_count: assert property (p_skip_count) else $error("skip count not stepped");

	property p_dec_one;
		s_q4(OP_DEC_SNZ) and (s_r.res != 8'h00) and !ixs_two_word(pm_data) |=> (s_r.skip == 2'h1);
	endproperty
	a_dec_one: assert property (p_dec_one) else $error("one-word skip not one cycle");

	property p_dec_noskip;
		s_q4(OP_DEC_SNZ) and (s_r.res == 8'h00) |=> (s_r.skip == 2'h0);
	endproperty
	a_dec_noskip: assert property (p_dec_noskip) else $error("zero decrement skipped");

	property p_incsz_skip;
		s_q4(OP_INC_SZ) and (s_r.res == 8'h00) |=> (s_r.skip != 2'h0);
	endproperty
	a_incsz_skip: assert property (p_incsz_skip) else $error("zero increment did not skip");

	property p_incsz_noskip;
		s_q4(OP_INC_SZ) and (s_r.res != 8'h00) |=> (s_r.skip == 2'h0);
	endproperty
	a_incsz_noskip: assert property (p_incsz_noskip) else $error("nonzero increment skipped");

	property p_dec_result;
		s_r.run && (s_r.q == Q3) && (exec_op == OP_DEC_SNZ) |=> (s_r.res == $past(s_r.opnd) - 8'h01);
	endproperty
	a_dec_result: assert property (p_dec_result) else $error("decrement result wrong");

	property p_inc_result;
		s_r.run && (s_r.q == Q3) && ((exec_op == OP_INC) || (exec_op == OP_INC_SZ))
			|=> (s_r.res == $past(s_r.opnd) + 8'h01);
	endproperty
	a_inc_result: assert property (p_inc_result) else $error("increment result wrong");

	property p_inc_flags_hi;
		s_q4(OP_INC) |=> (s_r.status[ST_N] == $past(s_r.res[7]))
			&& (s_r.status[ST_OV] == ($past(s_r.opnd) == BYTE_MAXPOS))
			&& (s_r.status[ST_DC] == ($past(s_r.opnd[3:0]) == NIB_ONES));
	endproperty
	a_inc_flags_hi: assert property (p_inc_flags_hi) else $error("increment sign flags wrong");

	property p_wreg_kept;
		(s_r.run && (s_r.q == Q4) && is_byte && dst_file) and s_no_sw_wreg |=> $stable(s_r.wreg);
	endproperty
	a_wreg_kept: assert property (p_wreg_kept) else $error("file destination touched accumulator");

endmodule : ixs_core

// [core/ixs_pkg.sv]
/*
 ixs_pkg: constants, types and helpers of the increment/decrement/jump executor.
 assumes a 12-bit APB byte address and a 16-bit program word.
*/
package ixs_pkg;

	// ****************
	// widths and map
	// ****************
	localparam int          PC_W        = 21;
	localparam int          FA_W        = 12;
	localparam logic [11:0] ADDR_CTRL   = 12'h000;
	localparam logic [11:0] ADDR_BANK   = 12'h004;
	localparam logic [11:0] ADDR_WREG   = 12'h008;
	localparam logic [11:0] ADDR_STATUS = 12'h00C;
	localparam logic [11:0] ADDR_PC     = 12'h010;
	localparam logic [11:0] ADDR_INDEX  = 12'h014;
	localparam int          CTRL_RUN    = 0;
	localparam int          CTRL_EXT    = 1;
	localparam int          ST_C        = 0;
	localparam int          ST_DC       = 1;
	localparam int          ST_Z        = 2;
	localparam int          ST_OV       = 3;
	localparam int          ST_N        = 4;

	// ****************
	// encodings
	// ****************
	localparam logic [7:0]      OPC_JUMP     = 8'hEF;
	localparam logic [5:0]      OPC_DEC_SNZ  = 6'h13;
	localparam logic [5:0]      OPC_INC      = 6'h0A;
	localparam logic [5:0]      OPC_INC_SZ   = 6'h0F;
	localparam logic [7:0]      ACC_LOW_MAX  = 8'h5F;
	localparam logic [7:0]      BYTE_ONES    = 8'hFF;
	localparam logic [7:0]      BYTE_MAXPOS  = 8'h7F;
	localparam logic [3:0]      NIB_ONES     = 4'hF;
	localparam logic [PC_W-1:0] PC_STEP      = 21'h0_0002;

	typedef enum logic [1:0] {Q1 = 2'b00, Q2 = 2'b01, Q3 = 2'b10, Q4 = 2'b11} ixs_quarter_type;
	typedef enum logic [2:0] {
		OP_NOP = 3'b000, OP_DEC_SNZ = 3'b001, OP_JUMP = 3'b010, OP_INC = 3'b011, OP_INC_SZ = 3'b100
	} ixs_op_type;

	typedef struct packed {
		logic            rd;
		logic            wr;
		logic [FA_W-1:0] addr;
		logic [7:0]      wdata;
	} ixs_file_req_type;

	typedef struct packed {
		ixs_quarter_type q;
		logic            run;
		logic            ext;
		logic [PC_W-1:0] pc;
		logic [15:0]     ir;
		logic [7:0]      wreg;
		logic [4:0]      status;
		logic [3:0]      bank_select_register;
		logic [FA_W-1:0] idx;
		logic [1:0]      skip;
		logic [7:0]      opnd;
		logic [7:0]      res;
		logic [7:0]      kl;
		logic [FA_W-1:0] faddr;
		logic [31:0]     prdata;
		logic            pslverr;
	} ixs_state_type;

	localparam ixs_state_type STATE_RST = '0;

	function automatic ixs_op_type ixs_decode(input logic [15:0] w);
		if (w[15:8] == OPC_JUMP) return OP_JUMP;
		if (w[15:10] == OPC_DEC_SNZ) return OP_DEC_SNZ;
		if (w[15:10] == OPC_INC) return OP_INC;
		if (w[15:10] == OPC_INC_SZ) return OP_INC_SZ;
		return OP_NOP;
	endfunction : ixs_decode

	function automatic logic ixs_two_word(input logic [15:0] w);
		return w[15:8] == OPC_JUMP;
	endfunction : ixs_two_word

endpackage : ixs_pkg

// [test/ixs_testbench.sv]
/*
 testbench: runs small programs on ixs_core over apb and checks file, accumulator and flags.
 assumes program memory and data file answer combinationally, as the core expects.
*/
`timescale 1ns/1ps
module testbench
	import ixs_pkg::*;
;
	typedef struct packed {
		logic [15:0] w;
		logic        ext;
		logic [11:0] fa;
		logic [7:0]  init;
		logic [7:0]  fres;
		logic [7:0]  wres;
		logic [4:0]  st;
		logic        skip;
	} ixs_row_type;

	logic             pclk;
	logic             presetn;
	logic             psel;
	logic             penable;
	logic             pwrite;
	logic [11:0]      paddr;
	logic [31:0]      pwdata;
	logic [31:0]      prdata;
	logic             pready;
	logic             pslverr;
	logic [PC_W-1:0]  pm_addr;
	logic [15:0]      pm_data;
	ixs_file_req_type file_req;
	logic [7:0]       file_rdata;
	logic [15:0]      pm [128];
	logic [7:0]       fmem [4096];
	int               wtime [4096];
	int               clk_n = 0;
	int               mismatches = 0;
	int               checks_done = 0;
	int               n;
	logic [31:0]      rd;
	logic             err;
	ixs_row_type      r;
	logic [19:0]      jk [3] = '{20'h5_A5C3, 20'hA_5A3C, 20'hF_FFFF};
	ixs_row_type      rows [10] = '{
		'{16'h2B20, 1'b0, 12'h320, 8'hFF, 8'h00, 8'h00, 5'h07, 1'b0},
		'{16'h2860, 1'b0, 12'hF60, 8'h7F, 8'h7F, 8'h80, 5'h1A, 1'b0},
		'{16'h2A10, 1'b1, 12'h210, 8'h0E, 8'h0F, 8'h00, 5'h00, 1'b0},
		'{16'h2A10, 1'b0, 12'h010, 8'h00, 8'h01, 8'h00, 5'h00, 1'b0},
		'{16'h2A5F, 1'b1, 12'h25F, 8'h80, 8'h81, 8'h00, 5'h10, 1'b0},
		'{16'h2A60, 1'b1, 12'hF60, 8'h0F, 8'h10, 8'h00, 5'h02, 1'b0},
		'{16'h4F40, 1'b0, 12'h340, 8'h01, 8'h00, 8'h00, 5'h1F, 1'b0},
		'{16'h4D40, 1'b0, 12'h340, 8'h05, 8'h05, 8'h04, 5'h1F, 1'b1},
		'{16'h3F50, 1'b0, 12'h350, 8'hFF, 8'h00, 8'h00, 5'h1F, 1'b1},
		'{16'h3C05, 1'b0, 12'h005, 8'h41, 8'h41, 8'h42, 5'h1F, 1'b0}};

	assign pm_data    = pm[pm_addr[7:1]];
	assign file_rdata = fmem[file_req.addr];

	ixs_core u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pm_addr(pm_addr), .pm_data(pm_data), .file_req(file_req), .file_rdata(file_rdata)
	);

	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	// data file; write times let skip lengths be measured as gaps
	always @(posedge pclk)
	begin
		clk_n <= clk_n + 1;
		if (file_req.wr === 1'b1)
		begin
			fmem[file_req.addr]  <= file_req.wdata;
			wtime[file_req.addr] <= clk_n;
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic test_done();
		if (mismatches == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
		begin
			k++;
			if (k > 50)
			begin
				check(32'h0000_0000, 32'h0000_0001);
				test_done();
			end
			@(posedge pclk);
		end
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	// reset is held while memories change, so a running core never fetches a half-loaded program
	task automatic load(input logic [15:0] a, b, c, d, e, f);
		presetn <= 1'b0;
		@(posedge pclk);
		foreach (pm[i])
			pm[i] = 16'h0000;
		foreach (fmem[i])
			fmem[i] = 8'h00;
		pm[0] = a;
		pm[1] = b;
		pm[2] = c;
		pm[3] = d;
		pm[4] = e;
		pm[5] = f;
	endtask : load

	task automatic go(input logic ext);
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, ADDR_BANK, 32'h0000_0003);
		apb(1'b1, ADDR_INDEX, 32'h0000_0200);
		apb(1'b1, ADDR_STATUS, 32'h0000_001F);
		apb(1'b1, ADDR_CTRL, ext ? 32'h0000_0003 : 32'h0000_0001);
	endtask : go

	initial
	begin
		presetn = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 12'h000;
		pwdata  = 32'h0000_0000;
		repeat (16) @(posedge pclk);
		check(32'(pm_addr), 32'h0000_0000);
		check(32'(file_req.rd), 32'h0000_0000);
		presetn <= 1'b1;
		apb(1'b0, ADDR_CTRL, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		apb(1'b0, 12'h018, 32'h0000_0000);
		check(32'(err), 32'h0000_0001);
		check(rd, 32'h0000_0000);
		// each row: operation, two markers, then a jump onto itself
		foreach (rows[i])
		begin
			r = rows[i];
			load(r.w, 16'h3F01, 16'h3F02, 16'hEF03, 16'hF000, 16'h0000);
			fmem[r.fa] = r.init;
			go(r.ext);
			repeat (60) @(posedge pclk);
			check(32'(fmem[r.fa]), 32'(r.fres));
			apb(1'b0, ADDR_WREG, 32'h0000_0000);
			check(rd, 32'(r.wres));
			apb(1'b0, ADDR_STATUS, 32'h0000_0000);
			check(rd, 32'(r.st));
			check(32'(fmem[12'h301]), 32'(!r.skip));
			check(32'(fmem[12'h302]), 32'h0000_0001);
		end
		foreach (jk[i])
		begin
			load({8'hEF, jk[i][7:0]}, {4'hF, jk[i][19:8]}, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
			go(1'b0);
			n = 0;
			while (pm_addr !== {jk[i], 1'b0})
			begin
				n++;
				if (n > 100)
				begin
					check(32'(pm_addr), 32'({jk[i], 1'b0}));
					test_done();
				end
				@(posedge pclk);
			end
			apb(1'b0, ADDR_STATUS, 32'h0000_0000);
			check(rd, 32'h0000_001F);
		end
		// a skipped two-word jump must cost two idle cycles, not one
		load(16'h4F40, 16'hEF10, 16'hF000, 16'h3F02, 16'hEF04, 16'hF000);
		fmem[12'h340] = 8'h05;
		go(1'b0);
		repeat (60) @(posedge pclk);
		check(32'(fmem[12'h340]), 32'h0000_0004);
		check(32'(fmem[12'h302]), 32'h0000_0001);
		check(32'(wtime[12'h302] - wtime[12'h340]), 32'h0000_000C);
		// reset in mid-run must stop the core and clear counter and flags at once
		presetn <= 1'b0;
		@(posedge pclk);
		check(32'(pm_addr), 32'h0000_0000);
		check(32'(file_req.wr), 32'h0000_0000);
		presetn <= 1'b1;
		apb(1'b0, ADDR_STATUS, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		apb(1'b0, ADDR_CTRL, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		test_done();
	end
endmodule : testbench
